// ===== hw/bridge_reset_pkg.sv
package bridge_reset_pkg;

  // Positions of the pin inputs inside the synchroniser vector.
  localparam int unsigned PIN_COUNT = 8;
  localparam int unsigned PIN_FUND = 0;
  localparam int unsigned PIN_AUX = 1;
  localparam int unsigned PIN_M66EN = 2;
  localparam int unsigned PIN_FRAME = 3;
  localparam int unsigned PIN_IRDY = 4;
  localparam int unsigned PIN_TRDY = 5;
  localparam int unsigned PIN_DEVSEL = 6;
  localparam int unsigned PIN_STOP = 7;

  // Reset value of the synchroniser: both resets asserted, bus strobes high.
  localparam logic [7:0] PIN_SYNC_RESET = 8'hf8;

  // Reset values of the outputs.
  localparam logic RESET_ASSERTED_N = 1'h0;
  localparam logic LINK_DOWN_AT_RESET = 1'h1;
  localparam logic ELEC_IDLE_AT_RESET = 1'h1;

  // Consecutive training sets with the reset bit needed for hot reset.
  localparam logic [1:0] HOT_RESET_TS_COUNT = 2'h2;

  // Symbol-time spacing of skip ordered sets that must be tolerated.
  localparam int unsigned SKIP_WIDTH = 11;
  localparam logic [10:0] SKIP_MIN_SYMBOLS = 11'h49c;
  localparam logic [10:0] SKIP_MAX_SYMBOLS = 11'h602;
  localparam logic [10:0] SYMBOL_COUNT_MAX = 11'h7ff;

  // Secondary bus clock rates in MHz.
  localparam logic [6:0] SEC_CLK_FAST_MHZ = 7'h42;
  localparam logic [6:0] SEC_CLK_SLOW_MHZ = 7'h21;

  // Transmitter electrical idle sequencing.
  typedef enum logic [1:0] {
    TX_ACTIVE = 2'h0,
    TX_SEND_EIOS = 2'h1,
    TX_ELEC_IDLE = 2'h3
  } tx_state_t;

endpackage

// ===== hw/bridge_reset_distribution.sv
module bridge_reset_distribution
  import bridge_reset_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Reset pins.
  input wire logic fundamental_reset_n,
  input wire logic aux_por_n,
  // Link layer ordered sets, on core_clk.
  input wire logic link_up,
  input wire logic os_valid,
  input wire logic os_ts,
  input wire logic os_reset_bit,
  input wire logic os_skip,
  input wire logic symbol_tick,
  // Bridge control reset bit, on core_clk.
  input wire logic sec_bus_reset_bit,
  // Transmitter idle control, on core_clk.
  input wire logic eidle_req,
  input wire logic eidle_exit,
  input wire logic tx_eios_done,
  // Secondary bus pins.
  input wire logic sec_m66en,
  input wire logic sec_frame_n,
  input wire logic sec_irdy_n,
  input wire logic sec_trdy_n,
  input wire logic sec_devsel_n,
  input wire logic sec_stop_n,
  // Reset outputs.
  output logic core_reset_n,
  output logic aux_reset_n,
  output logic nonsticky_reset_n,
  output logic link_layer_down,
  output logic hot_reset,
  output logic sec_pci_reset_n,
  // Skip and transmitter status.
  output logic skip_accept,
  output logic [10:0] skip_interval,
  output logic tx_send_eios,
  output logic tx_elec_idle,
  // Secondary bus status.
  output logic [6:0] sec_clk_mhz,
  output logic target_devsel,
  output logic target_trdy,
  output logic target_stop
);

  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_meta;
  logic [PIN_COUNT-1:0] pin_sync;
  logic fund_n;
  logic bus_busy;

  logic next_core_reset_n;
  logic next_aux_reset_n;
  logic next_nonsticky_reset_n;
  logic next_link_layer_down;
  logic next_hot_reset;
  logic next_sec_pci_reset_n;
  logic [1:0] ts_count;
  logic [1:0] next_ts_count;

  logic next_skip_accept;
  logic [10:0] next_skip_interval;
  logic [10:0] symbol_count;
  logic [10:0] next_symbol_count;

  tx_state_t tx_state;
  tx_state_t next_tx_state;
  logic next_tx_send_eios;
  logic next_tx_elec_idle;

  logic [6:0] next_sec_clk_mhz;
  logic next_target_devsel;
  logic next_target_trdy;
  logic next_target_stop;

  assign pin_raw = {sec_stop_n, sec_devsel_n, sec_trdy_n, sec_irdy_n, sec_frame_n, sec_m66en, aux_por_n,
                    fundamental_reset_n};

  // Two-flop synchronisers on every pin; the first stage feeds only the second.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta <= PIN_SYNC_RESET;
      pin_sync <= PIN_SYNC_RESET;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  assign fund_n = pin_sync[PIN_FUND];
  assign bus_busy = !pin_sync[PIN_FRAME] || !pin_sync[PIN_IRDY];

  // Reset distribution.
  always_comb begin
    next_core_reset_n = fund_n;
    next_aux_reset_n = pin_sync[PIN_AUX];
    next_ts_count = ts_count;
    next_hot_reset = hot_reset;
    if (!fund_n) begin
      next_ts_count = 2'h0;
      next_hot_reset = 1'h0;
    end else if (os_valid) begin
      if (os_ts && os_reset_bit) begin
        if (ts_count != HOT_RESET_TS_COUNT) begin
          next_ts_count = ts_count + 2'h1;
        end
        if (ts_count == HOT_RESET_TS_COUNT - 2'h1) begin
          next_hot_reset = 1'h1;
        end
      end else if (os_ts) begin
        next_ts_count = 2'h0;
        next_hot_reset = 1'h0;
      end else if (!os_skip) begin
        next_ts_count = 2'h0;
      end
    end
    next_link_layer_down = !fund_n || !link_up;
    next_nonsticky_reset_n = fund_n && !hot_reset && !link_layer_down;
    next_sec_pci_reset_n = nonsticky_reset_n && !sec_bus_reset_bit;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      core_reset_n <= RESET_ASSERTED_N;
      aux_reset_n <= RESET_ASSERTED_N;
      nonsticky_reset_n <= RESET_ASSERTED_N;
      link_layer_down <= LINK_DOWN_AT_RESET;
      hot_reset <= 1'h0;
      sec_pci_reset_n <= RESET_ASSERTED_N;
      ts_count <= 2'h0;
    end else begin
      core_reset_n <= next_core_reset_n;
      aux_reset_n <= next_aux_reset_n;
      nonsticky_reset_n <= next_nonsticky_reset_n;
      link_layer_down <= next_link_layer_down;
      hot_reset <= next_hot_reset;
      sec_pci_reset_n <= next_sec_pci_reset_n;
      ts_count <= next_ts_count;
    end
  end

  // Skip spacing measurement; any spacing is taken without error.
  always_comb begin
    next_skip_accept = 1'h0;
    next_skip_interval = skip_interval;
    next_symbol_count = symbol_count;
    if (!fund_n) begin
      next_symbol_count = 11'h000;
      next_skip_interval = 11'h000;
    end else if (os_valid && os_skip) begin
      next_skip_accept = 1'h1;
      next_skip_interval = symbol_count;
      next_symbol_count = 11'h000;
    end else if (symbol_tick && symbol_count != SYMBOL_COUNT_MAX) begin
      next_symbol_count = symbol_count + 11'h001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      skip_accept <= 1'h0;
      skip_interval <= 11'h000;
      symbol_count <= 11'h000;
    end else begin
      skip_accept <= next_skip_accept;
      skip_interval <= next_skip_interval;
      symbol_count <= next_symbol_count;
    end
  end

  // Transmitter electrical idle entry and exit.
  always_comb begin
    next_tx_state = tx_state;
    next_tx_send_eios = 1'h0;
    if (!fund_n) begin
      next_tx_state = TX_ELEC_IDLE;
    end else begin
      case (tx_state)
        TX_ACTIVE: begin
          if (eidle_req) begin
            next_tx_state = TX_SEND_EIOS;
            next_tx_send_eios = 1'h1;
          end
        end
        TX_SEND_EIOS: begin
          if (tx_eios_done) begin
            next_tx_state = TX_ELEC_IDLE;
          end
        end
        TX_ELEC_IDLE: begin
          if (eidle_exit) begin
            next_tx_state = TX_ACTIVE;
          end
        end
        default: begin
          next_tx_state = TX_ELEC_IDLE;
        end
      endcase
    end
    next_tx_elec_idle = (next_tx_state == TX_ELEC_IDLE);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state <= TX_ELEC_IDLE;
      tx_send_eios <= 1'h0;
      tx_elec_idle <= ELEC_IDLE_AT_RESET;
    end else begin
      tx_state <= next_tx_state;
      tx_send_eios <= next_tx_send_eios;
      tx_elec_idle <= next_tx_elec_idle;
    end
  end

  // Secondary bus rate and target response qualification.
  always_comb begin
    next_sec_clk_mhz = pin_sync[PIN_M66EN] ? SEC_CLK_FAST_MHZ : SEC_CLK_SLOW_MHZ;
    next_target_devsel = bus_busy && sec_pci_reset_n && !pin_sync[PIN_DEVSEL];
    next_target_trdy = bus_busy && sec_pci_reset_n && !pin_sync[PIN_TRDY];
    next_target_stop = bus_busy && sec_pci_reset_n && !pin_sync[PIN_STOP];
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sec_clk_mhz <= SEC_CLK_SLOW_MHZ;
      target_devsel <= 1'h0;
      target_trdy <= 1'h0;
      target_stop <= 1'h0;
    end else begin
      sec_clk_mhz <= next_sec_clk_mhz;
      target_devsel <= next_target_devsel;
      target_trdy <= next_target_trdy;
      target_stop <= next_target_stop;
    end
  end

  // Counts idle sets sent since the transmitter was last active.
  logic [1:0] eios_seen;
  logic [1:0] next_eios_seen;

  always_comb begin
    next_eios_seen = eios_seen;
    if (tx_state == TX_ACTIVE) begin
      next_eios_seen = 2'h0;
    end else if (tx_send_eios && eios_seen != 2'h3) begin
      next_eios_seen = eios_seen + 2'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      eios_seen <= 2'h0;
    end else begin
      eios_seen <= next_eios_seen;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  core_reset_hold_a: assert property (!fund_n |=> !core_reset_n && !hot_reset && !nonsticky_reset_n)
    else $error("Internal logic not held in reset during fundamental reset.");
  aux_reset_sync_a: assert property (##3 aux_reset_n == $past(aux_por_n, 3))
    else $error("Auxiliary reset does not follow its power-on detector.");
  hot_reset_entry_a: assert property (
    (fund_n && os_valid && os_ts && os_reset_bit ##1 fund_n && os_valid && os_ts && os_reset_bit) |=> hot_reset)
    else $error("Hot reset not entered after two reset training sets.");
  link_down_a: assert property ((fund_n && !link_up) |=> link_layer_down)
    else $error("Link down not reported.");
  nonsticky_clear_a: assert property (link_layer_down |=> !nonsticky_reset_n)
    else $error("Non-sticky state not reset while link layer down.");
  sec_reset_assert_a: assert property ((!nonsticky_reset_n || sec_bus_reset_bit) |=> !sec_pci_reset_n)
    else $error("Secondary reset not asserted for upstream reset.");
  sec_release_order_a: assert property ($rose(sec_pci_reset_n) |-> $past(nonsticky_reset_n, 1))
    else $error("Secondary reset released before upstream reset.");
  skip_no_error_a: assert property (
    (fund_n && os_valid && os_skip) |=> skip_accept && $stable(hot_reset) && $stable(ts_count))
    else $error("Skip set disturbed the receiver.");
  one_eios_a: assert property (
    ($past(tx_state) == TX_SEND_EIOS && tx_state == TX_ELEC_IDLE) |-> eios_seen == 2'h1)
    else $error("Idle entered without exactly one idle set.");
  sec_clk_rate_a: assert property (##1 sec_clk_mhz == ($past(pin_sync[PIN_M66EN]) ? 7'h42 : 7'h21))
    else $error("Secondary clock rate wrong.");
  idle_bus_ignore_a: assert property (!bus_busy |=> !target_devsel && !target_trdy && !target_stop)
    else $error("Target response taken on an idle bus.");
  core_release_sync_a: assert property (##3 core_reset_n == $past(fundamental_reset_n, 3))
    else $error("Core reset not synchronised to the clock.");

  hot_reset_seen_c: cover property ($rose(hot_reset));
  link_recover_c: cover property ($fell(link_layer_down) ##[1:20] $rose(sec_pci_reset_n));
  idle_entry_c: cover property (tx_send_eios ##[1:20] tx_elec_idle);
  skip_in_range_c: cover property (skip_accept && skip_interval >= SKIP_MIN_SYMBOLS
                                   && skip_interval <= SKIP_MAX_SYMBOLS);

endmodule // bridge_reset_distribution

// ===== sim/link_partner_model.sv
module link_partner_model (
  // Clock.
  input wire logic core_clk,
  // Transmitter handshake.
  input wire logic tx_send_eios,
  output logic tx_eios_done,
  // Received ordered sets.
  output logic os_valid,
  output logic os_ts,
  output logic os_reset_bit,
  output logic os_skip,
  output logic symbol_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  int done_delay = 1;
  initial begin
    {tx_eios_done, os_valid, os_ts, os_reset_bit, os_skip, symbol_tick} = 6'h00;
  end
  // Reports the idle set as sent after a chosen number of cycles.
  always @(posedge core_clk) begin
    if (tx_send_eios === 1'b1) begin
      repeat (done_delay) @(posedge core_clk);
      tx_eios_done <= 1'b1;
      @(posedge core_clk);
      tx_eios_done <= 1'b0;
    end
  end
  // Sends one ordered set; the qualifiers flip once the set is gone.
  task automatic send_os(input logic ts, input logic rb, input logic skip);
    @(posedge core_clk);
    {os_valid, os_ts, os_reset_bit, os_skip} <= {1'b1, ts, rb, skip};
    @(posedge core_clk);
    {os_valid, os_ts, os_reset_bit, os_skip} <= {1'b0, ~ts, ~rb, ~skip};
  endtask
  // Sends two identical ordered sets in back-to-back cycles.
  task automatic send_os_pair(input logic ts, input logic rb, input logic skip);
    @(posedge core_clk);
    {os_valid, os_ts, os_reset_bit, os_skip} <= {1'b1, ts, rb, skip};
    repeat (2) @(posedge core_clk);
    {os_valid, os_ts, os_reset_bit, os_skip} <= {1'b0, ~ts, ~rb, ~skip};
  endtask
  // Gives n symbol times.
  task automatic ticks(input int n);
    repeat (n) @(posedge core_clk) symbol_tick <= 1'b1;
    @(posedge core_clk);
    symbol_tick <= 1'b0;
  endtask
endmodule // link_partner_model

// ===== sim/bridge_reset_distribution_tb.sv
module bridge_reset_distribution_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_b, fundamental_reset_n, aux_por_n, link_up, sec_bus_reset_bit;
  logic eidle_req, eidle_exit, sec_m66en, sec_frame_n, sec_irdy_n, sec_trdy_n, sec_devsel_n, sec_stop_n;
  logic os_valid, os_ts, os_reset_bit, os_skip, symbol_tick, tx_eios_done;
  logic core_reset_n, aux_reset_n, nonsticky_reset_n, link_layer_down, hot_reset, sec_pci_reset_n;
  logic skip_accept, tx_send_eios, tx_elec_idle, target_devsel, target_trdy, target_stop;
  logic [10:0] skip_interval;
  logic [6:0] sec_clk_mhz;
  int miscompares = 0;
  int tests_run = 0;
  int eios_seen = 0;
  int seed = 32'h06af70df;
  int n, r, bad;
  int exp_skip;
  int skip_q[$];
  bridge_reset_distribution bridge_reset_distribution_inst (
    .core_clk(core_clk), .rst_b(rst_b), .fundamental_reset_n(fundamental_reset_n), .aux_por_n(aux_por_n),
    .link_up(link_up), .os_valid(os_valid), .os_ts(os_ts), .os_reset_bit(os_reset_bit), .os_skip(os_skip),
    .symbol_tick(symbol_tick), .sec_bus_reset_bit(sec_bus_reset_bit), .eidle_req(eidle_req),
    .eidle_exit(eidle_exit), .tx_eios_done(tx_eios_done), .sec_m66en(sec_m66en), .sec_frame_n(sec_frame_n),
    .sec_irdy_n(sec_irdy_n), .sec_trdy_n(sec_trdy_n), .sec_devsel_n(sec_devsel_n), .sec_stop_n(sec_stop_n),
    .core_reset_n(core_reset_n), .aux_reset_n(aux_reset_n), .nonsticky_reset_n(nonsticky_reset_n),
    .link_layer_down(link_layer_down), .hot_reset(hot_reset), .sec_pci_reset_n(sec_pci_reset_n),
    .skip_accept(skip_accept), .skip_interval(skip_interval), .tx_send_eios(tx_send_eios),
    .tx_elec_idle(tx_elec_idle), .sec_clk_mhz(sec_clk_mhz), .target_devsel(target_devsel),
    .target_trdy(target_trdy), .target_stop(target_stop)
  );
  link_partner_model link_partner_model_inst (
    .core_clk(core_clk), .tx_send_eios(tx_send_eios), .tx_eios_done(tx_eios_done), .os_valid(os_valid),
    .os_ts(os_ts), .os_reset_bit(os_reset_bit), .os_skip(os_skip), .symbol_tick(symbol_tick)
  );
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (tx_send_eios === 1'b1) eios_seen++;
  // Skip model: every accepted skip must match the next expected spacing in the queue.
  always @(posedge core_clk) begin
    if (skip_accept === 1'b1) begin
      exp_skip = (skip_q.size() > 0) ? skip_q.pop_front() : -1;
      check("skip_model", exp_skip[10:0], skip_interval);
    end
  end
  task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wait_chk(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Releases the fundamental reset and watches the secondary reset never lead it.
  task automatic release_fund;
    bad = 0;
    @(posedge core_clk) fundamental_reset_n <= 1'b1;
    repeat (8) begin
      wait_chk(1);
      if (sec_pci_reset_n === 1'b1 && core_reset_n !== 1'b1) bad++;
    end
    check("order", 0, bad[10:0]);
    check("core", 1, core_reset_n);
    check("sec", 1, sec_pci_reset_n);
    check("lld", 0, link_layer_down);
  endtask
  initial begin
    #2000000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    {rst_b, fundamental_reset_n, aux_por_n, link_up, sec_bus_reset_bit, eidle_req, eidle_exit} = 7'h00;
    {sec_m66en, sec_frame_n, sec_irdy_n, sec_trdy_n, sec_devsel_n, sec_stop_n} = 6'h1f;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    wait_chk(2);
    check("idle", 1, tx_elec_idle);
    @(posedge core_clk) aux_por_n <= 1'b1;
    link_up <= 1'b1;
    wait_chk(5);
    check("aux", 1, aux_reset_n);
    check("core", 0, core_reset_n);
    release_fund();
    @(posedge core_clk) fundamental_reset_n <= 1'b0;
    wait_chk(5);
    check("core", 0, core_reset_n);
    check("aux", 1, aux_reset_n);
    check("sec", 0, sec_pci_reset_n);
    release_fund();
    $display("Reset pins done");
    link_partner_model_inst.send_os(1'b1, 1'b1, 1'b0);
    skip_q.push_back(0);
    link_partner_model_inst.send_os(1'b0, 1'b0, 1'b1);
    link_partner_model_inst.send_os(1'b1, 1'b1, 1'b0);
    wait_chk(4);
    check("hot", 1, hot_reset);
    check("nonsticky", 0, nonsticky_reset_n);
    check("sec", 0, sec_pci_reset_n);
    link_partner_model_inst.send_os(1'b1, 1'b0, 1'b0);
    wait_chk(4);
    check("hot", 0, hot_reset);
    check("sec", 1, sec_pci_reset_n);
    link_partner_model_inst.send_os(1'b1, 1'b1, 1'b0);
    link_partner_model_inst.send_os(1'b0, 1'b0, 1'b0);
    link_partner_model_inst.send_os(1'b1, 1'b1, 1'b0);
    wait_chk(4);
    check("hot", 0, hot_reset);
    link_partner_model_inst.send_os(1'b1, 1'b0, 1'b0);
    link_partner_model_inst.send_os_pair(1'b1, 1'b1, 1'b0);
    wait_chk(4);
    check("hot_pair", 1, hot_reset);
    link_partner_model_inst.send_os(1'b1, 1'b0, 1'b0);
    wait_chk(4);
    check("hot", 0, hot_reset);
    $display("Hot reset done");
    @(posedge core_clk) link_up <= 1'b0;
    wait_chk(5);
    check("lld", 1, link_layer_down);
    check("nonsticky", 0, nonsticky_reset_n);
    check("aux", 1, aux_reset_n);
    check("sec", 0, sec_pci_reset_n);
    @(posedge core_clk) link_up <= 1'b1;
    wait_chk(5);
    check("sec", 1, sec_pci_reset_n);
    @(posedge core_clk) sec_bus_reset_bit <= 1'b1;
    wait_chk(4);
    check("sec", 0, sec_pci_reset_n);
    @(posedge core_clk) sec_bus_reset_bit <= 1'b0;
    wait_chk(4);
    $display("Link down done");
    skip_q.push_back(0);
    link_partner_model_inst.send_os(1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 3; i++) begin
      r = $random(seed);
      n = (i == 0) ? 1180 : (i == 1) ? 1538 : 1180 + (r & 32'hff);
      skip_q.push_back(n);
      link_partner_model_inst.ticks(n);
      link_partner_model_inst.send_os(1'b0, 1'b0, 1'b1);
      bad = 0;
      repeat (3) begin
        #1;
        if (skip_accept === 1'b1) bad++;
        @(posedge core_clk);
      end
      check("skip_accept", 1, bad[10:0]);
      check("skip_interval", n[10:0], skip_interval);
    end
    $display("Skip done");
    for (int d = 1; d < 8; d += 5) begin
      link_partner_model_inst.done_delay = d;
      @(posedge core_clk) eidle_exit <= 1'b1;
      @(posedge core_clk) eidle_exit <= 1'b0;
      wait_chk(2);
      check("active", 0, tx_elec_idle);
      eios_seen = 0;
      @(posedge core_clk) eidle_req <= 1'b1;
      @(posedge core_clk) eidle_req <= 1'b0;
      wait_chk(d + 6);
      check("eios", 1, eios_seen[10:0]);
      check("idle", 1, tx_elec_idle);
    end
    $display("Idle done");
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      @(posedge core_clk);
      {sec_m66en, sec_stop_n, sec_trdy_n, sec_devsel_n, sec_irdy_n} <= r[4:0];
      sec_frame_n <= i[0];
      wait_chk(5);
      n = (i[0] == 1'b0 || r[0] == 1'b0) ? 1 : 0;
      check("devsel", n[0] & ~r[1], target_devsel);
      check("trdy", n[0] & ~r[2], target_trdy);
      check("stop", n[0] & ~r[3], target_stop);
      check("clk", r[4] ? 11'h042 : 11'h021, {4'h0, sec_clk_mhz});
    end
    $display("Secondary bus done");
    tally_and_finish();
  end
endmodule // bridge_reset_distribution_tb
